// ### src/mprs_pkg.sv
// Package: offsets, field positions and reset values of the status bank
package mprs_pkg;

    localparam logic [7:0]  MPRS_OFF_PARAMS = 8'he6;
    localparam logic [7:0]  MPRS_OFF_STATUS = 8'he8;
    localparam logic [31:0] MPRS_RESET_VAL  = 32'h0000_0000;

    localparam int MPRS_RES_MSB   = 31;
    localparam int MPRS_RES_LSB   = 24;
    localparam int MPRS_BEMF_MSB  = 23;
    localparam int MPRS_BEMF_LSB  = 16;
    localparam int MPRS_IND_MSB   = 15;
    localparam int MPRS_IND_LSB   = 8;

    localparam int MPRS_FLAG_RES  = 31;
    localparam int MPRS_FLAG_IND  = 30;
    localparam int MPRS_FLAG_BEMF = 29;
    localparam int MPRS_FLAG_MECH = 28;
    localparam int MPRS_FREQ_MSB  = 27;
    localparam int MPRS_FREQ_LSB  = 24;

endpackage : mprs_pkg

// ### src/mprs_regs.sv
// Read-only bank holding motor parameter measurement results
`timescale 1ns/1ps

module mprs_regs (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        reg_rd,
    input  wire logic        reg_wr,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    input  wire logic        res_done,
    input  wire logic [7:0]  res_value,
    input  wire logic        res_flag,
    input  wire logic        bemf_done,
    input  wire logic [7:0]  bemf_value,
    input  wire logic        bemf_flag,
    input  wire logic        ind_done,
    input  wire logic [7:0]  ind_value,
    input  wire logic        ind_flag,
    input  wire logic        mech_done,
    input  wire logic        mech_flag,
    input  wire logic        freq_done,
    input  wire logic [3:0]  freq_code
);

    // ****************************************************************
    // Result storage
    // ****************************************************************
    logic [7:0] res_q,  res_d;
    logic [7:0] bemf_q, bemf_d;
    logic [7:0] ind_q,  ind_d;
    logic [3:0] freq_q, freq_d;
    logic       res_flag_q,  res_flag_d;
    logic       bemf_flag_q, bemf_flag_d;
    logic       ind_flag_q,  ind_flag_d;
    logic       mech_flag_q, mech_flag_d;
    logic [31:0] rdata_q, rdata_d;
    logic [31:0] params_w;
    logic [31:0] status_w;

    // Write strobe and data are deliberately unused: bank is read-only
    // writes never load
    always_comb begin
        res_d       = res_done  ? res_value  : res_q;
        res_flag_d  = res_done  ? res_flag   : res_flag_q;
        bemf_d      = bemf_done ? bemf_value : bemf_q;
        bemf_flag_d = bemf_done ? bemf_flag  : bemf_flag_q;
        ind_d       = ind_done  ? ind_value  : ind_q;
        ind_flag_d  = ind_done  ? ind_flag   : ind_flag_q;
        mech_flag_d = mech_done ? mech_flag  : mech_flag_q;
        freq_d      = freq_done ? freq_code  : freq_q;
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            res_q       <= mprs_pkg::MPRS_RESET_VAL[7:0];
            bemf_q      <= mprs_pkg::MPRS_RESET_VAL[7:0];
            ind_q       <= mprs_pkg::MPRS_RESET_VAL[7:0];
            freq_q      <= mprs_pkg::MPRS_RESET_VAL[3:0];
            res_flag_q  <= 1'h0;
            bemf_flag_q <= 1'h0;
            ind_flag_q  <= 1'h0;
            mech_flag_q <= 1'h0;
        end else begin
            res_q       <= res_d;
            bemf_q      <= bemf_d;
            ind_q       <= ind_d;
            freq_q      <= freq_d;
            res_flag_q  <= res_flag_d;
            bemf_flag_q <= bemf_flag_d;
            ind_flag_q  <= ind_flag_d;
            mech_flag_q <= mech_flag_d;
        end
    end

    // ****************************************************************
    // Word assembly and read port
    // ****************************************************************
    always_comb begin
        params_w = 32'h0000_0000;
        status_w = 32'h0000_0000;
        params_w[mprs_pkg::MPRS_RES_MSB:mprs_pkg::MPRS_RES_LSB] = res_q;
        params_w[mprs_pkg::MPRS_BEMF_MSB:mprs_pkg::MPRS_BEMF_LSB] = bemf_q;
        params_w[mprs_pkg::MPRS_IND_MSB:mprs_pkg::MPRS_IND_LSB] = ind_q;
        status_w[mprs_pkg::MPRS_FLAG_RES] = res_flag_q;
        status_w[mprs_pkg::MPRS_FLAG_IND] = ind_flag_q;
        status_w[mprs_pkg::MPRS_FLAG_BEMF] = bemf_flag_q;
        status_w[mprs_pkg::MPRS_FLAG_MECH] = mech_flag_q;
        status_w[mprs_pkg::MPRS_FREQ_MSB:mprs_pkg::MPRS_FREQ_LSB] = freq_q;
    end

    // Undefined offsets read zero so software sees no stray state
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            unique case (reg_addr)
                mprs_pkg::MPRS_OFF_PARAMS: rdata_d = params_w;
                mprs_pkg::MPRS_OFF_STATUS: rdata_d = status_w;
                default:                   rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            rdata_q <= mprs_pkg::MPRS_RESET_VAL;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign reg_rdata = rdata_q;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_write_ignored: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_wr && !res_done) |=> (res_q == $past(res_q)))
        else $error("Write changed resistance value");

    a_res_atomic: assert property (
        @(posedge mclk) disable iff (srst)
        res_done |=> (res_q == $past(res_value))
                     && (res_flag_q == $past(res_flag)))
        else $error("Resistance value and flag not loaded together");

    a_params_read: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_PARAMS && !res_done)
        |=> (reg_rdata[31:24] == res_q))
        else $error("Resistance read mismatch");

    a_bemf_read: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_PARAMS && !bemf_done)
        |=> (reg_rdata[23:16] == bemf_q))
        else $error("Back-EMF read mismatch");

    a_params_low: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_PARAMS && !ind_done)
        |=> (reg_rdata[15:8] == ind_q) && (reg_rdata[7:0] == 8'h00))
        else $error("Inductance or reserved bits wrong");

    a_status_flags: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS
         && !res_done && !ind_done && !bemf_done && !mech_done)
        |=> (reg_rdata[31:28] ==
             {res_flag_q, ind_flag_q, bemf_flag_q, mech_flag_q}))
        else $error("Status flag order wrong");

    a_status_low: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS && !freq_done)
        |=> (reg_rdata[27:24] == freq_q) && (reg_rdata[23:0] == 24'h0))
        else $error("Frequency code or reserved bits wrong");

    a_reset_clear: assert property (
        @(posedge mclk)
        srst |=> (reg_rdata == 32'h0) && (freq_q == 4'h0)
                 && (res_q == 8'h00) && !mech_flag_q)
        else $error("Reset did not clear bank");

    // ****************************************************************
    // Load checks per measurement
    // ****************************************************************
    // A torn update would pair a new value with a stale flag
    a_bemf_atomic: assert property (
        @(posedge mclk) disable iff (srst)
        bemf_done |=> (bemf_q == $past(bemf_value))
                      && (bemf_flag_q == $past(bemf_flag)))
        else $error("Back-EMF value and flag not loaded together");

    a_ind_atomic: assert property (
        @(posedge mclk) disable iff (srst)
        ind_done |=> (ind_q == $past(ind_value))
                     && (ind_flag_q == $past(ind_flag)))
        else $error("Inductance value and flag not loaded together");

    a_mech_load: assert property (
        @(posedge mclk) disable iff (srst)
        mech_done |=> (mech_flag_q == $past(mech_flag)))
        else $error("Mechanical flag not loaded");

    a_freq_load: assert property (
        @(posedge mclk) disable iff (srst)
        freq_done |=> (freq_q == $past(freq_code)))
        else $error("Frequency code not loaded");

    // ****************************************************************
    // Hold checks
    // ****************************************************************
    // Only a finished measurement may move a field; bus traffic never
    a_res_hold: assert property (
        @(posedge mclk) disable iff (srst)
        !res_done |=> (res_q == $past(res_q))
                      && (res_flag_q == $past(res_flag_q)))
        else $error("Resistance field moved without a load");

    a_bemf_hold: assert property (
        @(posedge mclk) disable iff (srst)
        !bemf_done |=> (bemf_q == $past(bemf_q))
                       && (bemf_flag_q == $past(bemf_flag_q)))
        else $error("Back-EMF field moved without a load");

    a_ind_hold: assert property (
        @(posedge mclk) disable iff (srst)
        !ind_done |=> (ind_q == $past(ind_q))
                      && (ind_flag_q == $past(ind_flag_q)))
        else $error("Inductance field moved without a load");

    a_mech_hold: assert property (
        @(posedge mclk) disable iff (srst)
        !mech_done |=> (mech_flag_q == $past(mech_flag_q)))
        else $error("Mechanical flag moved without a load");

    a_freq_hold: assert property (
        @(posedge mclk) disable iff (srst)
        !freq_done |=> (freq_q == $past(freq_q)))
        else $error("Frequency code moved without a load");

    // Read data stands until the next read, whatever the write strobe does
    a_rdata_stands: assert property (
        @(posedge mclk) disable iff (srst)
        !reg_rd |=> (reg_rdata == $past(reg_rdata)))
        else $error("Read data changed without a read");

    // ****************************************************************
    // Read word checks
    // ****************************************************************
    a_ind_flag_read: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS && !ind_done)
        |=> (reg_rdata[30] == ind_flag_q))
        else $error("Inductance flag read mismatch");

    a_bemf_flag_read: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS && !bemf_done)
        |=> (reg_rdata[29] == bemf_flag_q))
        else $error("Back-EMF flag read mismatch");

    a_mech_flag_read: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS && !mech_done)
        |=> (reg_rdata[28] == mech_flag_q))
        else $error("Mechanical flag read mismatch");

    a_params_word: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_PARAMS
         && !res_done && !bemf_done && !ind_done)
        |=> (reg_rdata == {res_q, bemf_q, ind_q, 8'h00}))
        else $error("Parameter word read mismatch");

    a_status_word: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr == mprs_pkg::MPRS_OFF_STATUS
         && !res_done && !ind_done && !bemf_done && !mech_done
         && !freq_done)
        |=> (reg_rdata == {res_flag_q, ind_flag_q, bemf_flag_q,
                           mech_flag_q, freq_q, 24'h00_0000}))
        else $error("Status word read mismatch");

    // Reserved offsets read zero so no stray state leaks out
    a_unmapped_zero: assert property (
        @(posedge mclk) disable iff (srst)
        (reg_rd && reg_addr != mprs_pkg::MPRS_OFF_PARAMS
         && reg_addr != mprs_pkg::MPRS_OFF_STATUS)
        |=> (reg_rdata == 32'h0000_0000))
        else $error("Undefined offset read nonzero");

    // ****************************************************************
    // Reset checks
    // ****************************************************************
    a_params_reset: assert property (
        @(posedge mclk)
        srst |=> (res_q == 8'h00) && (bemf_q == 8'h00) && (ind_q == 8'h00))
        else $error("Reset did not clear parameter fields");

    a_flags_reset: assert property (
        @(posedge mclk)
        srst |=> !res_flag_q && !ind_flag_q && !bemf_flag_q
                 && !mech_flag_q && (freq_q == 4'h0))
        else $error("Reset did not clear status fields");

endmodule : mprs_regs

// ### test/mprs_regs_test.sv
// Self-checking bench for the motor parameter status register bank
`timescale 1ns/1ps

module mprs_regs_test;
    typedef struct packed {
        logic [7:0]  r;
        logic [7:0]  b;
        logic [7:0]  i;
        logic [3:0]  fl;
        logic [3:0]  fc;
        logic [31:0] par;
        logic [31:0] sts;
    } mprs_row_t;

    logic        mclk      = 1'b0;
    logic        srst      = 1'b1;
    logic        reg_rd    = 1'b0;
    logic        reg_wr    = 1'b0;
    logic [7:0]  reg_addr  = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic [31:0] reg_rdata;
    logic [4:0]  done      = 5'h00;
    logic [7:0]  r         = 8'h00;
    logic [7:0]  b         = 8'h00;
    logic [7:0]  i         = 8'h00;
    logic [3:0]  fl        = 4'h0;
    logic [3:0]  fc        = 4'h0;
    int          miscompares     = 0;
    int          samples_checked = 0;
    mprs_row_t   rows [4];

    always #2.5 mclk = ~mclk;

    mprs_regs dut_u (.mclk(mclk), .srst(srst), .reg_rd(reg_rd),
        .reg_wr(reg_wr), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .res_done(done[4]), .res_value(r),
        .res_flag(fl[3]), .bemf_done(done[3]), .bemf_value(b),
        .bemf_flag(fl[1]), .ind_done(done[2]), .ind_value(i),
        .ind_flag(fl[2]), .mech_done(done[1]), .mech_flag(fl[0]),
        .freq_done(done[0]), .freq_code(fc));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic complete_run;
        $display("checked %0d, wrong %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : complete_run

    task automatic check(logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check

    // Data stands from the edge that takes the read
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        @(posedge mclk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask : rd

    task automatic load(logic [4:0] m, mprs_row_t w);
        @(posedge mclk);
        done <= m;
        {r, b, i, fl, fc} <= {w.r, w.b, w.i, w.fl, w.fc};
        @(posedge mclk);
        done <= 5'h00;
    endtask : load

    // ****************************************
    // Watchdog
    // ****************************************
    initial begin
        repeat (2000) @(posedge mclk);
        miscompares++;
        complete_run();
    end

    initial begin
        rows[0] = {8'h12, 8'h34, 8'h56, 4'ha, 4'h7, 32'h12345600, 32'ha7000000};
        rows[1] = {8'hff, 8'hff, 8'hff, 4'hf, 4'hf, 32'hffffff00, 32'hff000000};
        rows[2] = {8'h80, 8'h01, 8'h00, 4'h4, 4'h1, 32'h80010000, 32'h41000000};
        rows[3] = {8'h01, 8'h80, 8'h00, 4'h1, 4'h0, 32'h01800000, 32'h10000000};
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
        // Field placement in both words
        foreach (rows[k]) begin
            load(5'h1f, rows[k]);
            rd(8'he6, rows[k].par);
            rd(8'he8, rows[k].sts);
        end
        $display("field table done");
        // Writes must leave both words alone
        @(posedge mclk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, 8'he6, 32'hffff_ffff};
        @(posedge mclk);
        reg_addr <= 8'he8;
        @(posedge mclk);
        reg_wr <= 1'b0;
        rd(8'he6, 32'h01800000);
        rd(8'he8, 32'h10000000);
        rd(8'he4, 32'h0000_0000);
        rd(8'hea, 32'h0000_0000);
        $display("write and unmapped done");
        // Only the finished measurement changes; flag goes with value
        load(5'h10, {8'h5a, 8'h00, 8'h00, 4'h8, 4'h0, 64'h0});
        rd(8'he6, 32'h5a800000);
        rd(8'he8, 32'h90000000);
        // Read taken with the done edge still sees the old word
        @(posedge mclk);
        {done, r, reg_rd, reg_addr} <= {5'h10, 8'h77, 1'b1, 8'he6};
        @(posedge mclk);
        {done, reg_rd} <= {5'h00, 1'b0};
        #1;
        check(reg_rdata, 32'h5a800000);
        rd(8'he6, 32'h77800000);
        // A lone inductance result leaves the other fields alone
        load(5'h04, {8'h00, 8'h00, 8'h3c, 4'h4, 4'h0, 64'h0});
        rd(8'he6, 32'h77803c00);
        rd(8'he8, 32'hd0000000);
        $display("partial update done");
        // Reset in mid-run clears both words
        @(posedge mclk);
        srst <= 1'b1;
        @(posedge mclk);
        srst <= 1'b0;
        rd(8'he6, mprs_pkg::MPRS_RESET_VAL);
        rd(8'he8, mprs_pkg::MPRS_RESET_VAL);
        $display("reset done");
        complete_run();
    end
endmodule : mprs_regs_test
